// ---- design/pig_apb_slave.sv ----
// apb slave front end: one wait-free access phase per transfer
// assumes register logic answers combinationally on the bus carrier
`timescale 1ns/100ps
`default_nettype none
module pig_apb_slave (
   input wire logic clock, // bus clock
   input wire logic rst_n, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [pig_pkg::ADDR_W-1:0] paddr, // apb byte address
   input wire logic [pig_pkg::DATA_W-1:0] pwdata, // apb write data
   output logic [pig_pkg::DATA_W-1:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   pig_bus_if.front bus // toward register logic
);
   import pig_pkg::*;

   pig_apb_state_type st_reg;
   pig_apb_state_type st_next;
   logic aligned;

   // decode and strobes toward the registers
   assign bus.index = paddr[ADDR_W-1:2];
   assign bus.wdata = pwdata[REG_W-1:0];
   assign bus.setup = psel && !penable;
   assign aligned = (paddr[1:0] == WORD_ALIGN);
   assign bus.wr_stb = psel && penable && st_reg.ready && pwrite &&
                       aligned && bus.mapped;

   // answer is prepared in setup and shown during access
   always_comb begin
      st_next = st_reg;
      st_next.ready = bus.setup;
      if (bus.setup) begin
         st_next.slverr = !(aligned && bus.mapped);
         st_next.rdata = ZERO_WORD;
         if (!pwrite && aligned) begin
            st_next.rdata[REG_W-1:0] = bus.rdata;
         end
      end else begin
         st_next.slverr = 1'b0;
         st_next.rdata = ZERO_WORD;
      end
   end

   // state registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.rdata;
   assign pready = st_reg.ready;
   assign pslverr = st_reg.slverr;

endmodule : pig_apb_slave
`default_nettype wire

// ---- design/pig_bus_if.sv ----
// carrier between the apb front end and the register logic
// assumes both ends share one clock
`timescale 1ns/100ps
`default_nettype none
interface pig_bus_if;
   import pig_pkg::*;
   logic setup; // setup phase of a transfer
   logic wr_stb; // write commits this edge
   logic [IDX_W-1:0] index; // register index
   logic [REG_W-1:0] wdata; // write byte
   logic [REG_W-1:0] rdata; // read byte for current index
   logic mapped; // index decodes
   modport front(output setup, wr_stb, index, wdata,
                 input rdata, mapped);
   modport regs(input setup, wr_stb, index, wdata,
                output rdata, mapped);
endinterface : pig_bus_if
`default_nettype wire

// ---- design/pig_gpio_top.sv ----
// pin integration unit: port a and port c general purpose pins
// assumes apb on the 10 MHz bus clock; spi and die link on same clock
//
// Operation
// - output pin reads back its data latch
// - input pin reads synchronised pin level
// - direction one drives pin from latch
// - direction zero leaves pin high impedance
// - port a direction covers pins five..zero
// - spi use overrides port a direction
// - override never changes stored direction bits
// - pin three slave select, two clock
// - pin one mosi, pin zero miso
// - unused peripheral pins act as gpio
// - spare slots one, three read zero
// - port c latch: interrupt bit1, clock bit0
// - data and direction accessible any time
// - die link use overrides port c direction
`timescale 1ns/100ps
`default_nettype none
module pig_gpio_top (
   input wire logic clock, // bus clock, 10 MHz
   input wire logic rst_n, // async reset, active low
   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [pig_pkg::ADDR_W-1:0] paddr, // apb byte address
   input wire logic [pig_pkg::DATA_W-1:0] pwdata, // apb write data
   output logic [pig_pkg::DATA_W-1:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped or unaligned
   // ----------------------------------------------------------------
   // port a pins
   // ----------------------------------------------------------------
   input wire logic [pig_pkg::PA_W-1:0] pa_pin_in, // pin levels
   output logic [pig_pkg::PA_W-1:0] pa_pin_out, // pin drive values
   output logic [pig_pkg::PA_W-1:0] pa_pin_oe, // high while driven
   // ----------------------------------------------------------------
   // port c pins
   // ----------------------------------------------------------------
   input wire logic [pig_pkg::PC_W-1:0] pc_pin_in, // pin levels
   output logic [pig_pkg::PC_W-1:0] pc_pin_out, // pin drive values
   output logic [pig_pkg::PC_W-1:0] pc_pin_oe, // high while driven
   // ----------------------------------------------------------------
   // spi module side
   // ----------------------------------------------------------------
   input wire logic [pig_pkg::SPI_W-1:0] spi_pin_use, // spi owns pin
   input wire logic [pig_pkg::SPI_W-1:0] spi_pin_drive, // spi out value
   input wire logic [pig_pkg::SPI_W-1:0] spi_pin_oe, // spi drives pin
   output logic [pig_pkg::SPI_W-1:0] spi_pin_level, // synced pin levels
   // ----------------------------------------------------------------
   // die link side
   // ----------------------------------------------------------------
   input wire logic [pig_pkg::PC_W-1:0] die_link_pin_use, // link owns
   input wire logic die_link_clock_out, // link clock to pin 0
   input wire logic [pig_pkg::PC_W-1:0] die_link_pin_oe, // link drives
   output logic die_link_interrupt_in // synced pin 1 level
);
   import pig_pkg::*;

   // ----------------------------------------------------------------
   // local signals
   // ----------------------------------------------------------------
   pig_gpio_state_type st_reg;
   pig_gpio_state_type st_next;
   logic [PIN_W-1:0] pin_sync;
   logic [PA_W-1:0] pa_sync;
   logic [PC_W-1:0] pc_sync;
   logic [PA_W-1:0] pa_read;
   logic [PC_W-1:0] pc_read;
   logic [PA_W-1:0] pa_use;
   logic [PA_W-1:0] pa_alt_out;
   logic [PA_W-1:0] pa_alt_oe;
   logic [PC_W-1:0] pc_alt_out;

   pig_bus_if bus();

   // ----------------------------------------------------------------
   // submodules
   // ----------------------------------------------------------------

   // apb front end
   pig_apb_slave u_apb (
      .clock(clock),
      .rst_n(rst_n),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .bus(bus.front)
   );

   // pin level synchroniser, port c in the upper bits
   pig_sync u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .pin_async({pc_pin_in, pa_pin_in}),
      .pin_sync(pin_sync)
   );

   assign pa_sync = pin_sync[PA_W-1:0];
   assign pc_sync = pin_sync[PIN_W-1:PA_W];

   // ----------------------------------------------------------------
   // peripheral routing
   // ----------------------------------------------------------------

   // spi signals sit on port a pins 3..0, pins 5..4 have none
   always_comb begin
      pa_use = PA_RESET;
      pa_alt_out = PA_RESET;
      pa_alt_oe = PA_RESET;
      pa_use[PA_SS_BIT] = spi_pin_use[PA_SS_BIT];
      pa_use[PA_SCK_BIT] = spi_pin_use[PA_SCK_BIT];
      pa_use[PA_MOSI_BIT] = spi_pin_use[PA_MOSI_BIT];
      pa_use[PA_MISO_BIT] = spi_pin_use[PA_MISO_BIT];
      pa_alt_out[SPI_W-1:0] = spi_pin_drive;
      pa_alt_oe[SPI_W-1:0] = spi_pin_oe;
   end

   // die link clock on pin 0, interrupt pin 1 has no link value and drives zero when the link enables it
   always_comb begin
      pc_alt_out = PC_RESET;
      pc_alt_out[PC_CLK_BIT] = die_link_clock_out;
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------

   // output pins read back latch, input pins read synced level
   always_comb begin
      for (int i = 0; i < PA_W; i++) begin
         pa_read[i] = st_reg.pa_dir[i] ? st_reg.pa_latch[i]
                                       : pa_sync[i];
      end
      for (int i = 0; i < PC_W; i++) begin
         pc_read[i] = st_reg.pc_dir[i] ? st_reg.pc_latch[i]
                                       : pc_sync[i];
      end
   end

   // byte mux; spare slots and upper bits read zero
   always_comb begin
      bus.rdata = ZERO_BYTE;
      bus.mapped = pig_mapped(bus.index);
      unique case (bus.index)
         IDX_PA_LATCH: bus.rdata[PA_W-1:0] = pa_read;
         IDX_PA_DIR: bus.rdata[PA_W-1:0] = st_reg.pa_dir;
         IDX_PC_LATCH: bus.rdata[PC_W-1:0] = pc_read;
         IDX_PC_DIR: bus.rdata[PC_W-1:0] = st_reg.pc_dir;
         default: bus.rdata = ZERO_BYTE;
      endcase
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;

      // register writes, accepted whenever the bus commits one
      if (bus.wr_stb) begin
         unique case (bus.index)
            IDX_PA_LATCH: st_next.pa_latch = bus.wdata[PA_W-1:0];
            IDX_PA_DIR: st_next.pa_dir = bus.wdata[PA_W-1:0];
            IDX_PC_LATCH: st_next.pc_latch = bus.wdata[PC_W-1:0];
            IDX_PC_DIR: st_next.pc_dir = bus.wdata[PC_W-1:0];
            default: st_next = st_reg; // spare slots ignore
         endcase
      end

      // port a drive: spi owns a pin only while it uses it
      for (int i = 0; i < PA_W; i++) begin
         if (pa_use[i]) begin
            st_next.pa_oe[i] = pa_alt_oe[i];
            st_next.pa_out[i] = pa_alt_out[i];
         end else begin
            st_next.pa_oe[i] = st_next.pa_dir[i];
            st_next.pa_out[i] = st_next.pa_latch[i];
         end
      end

      // port c drive: die link owns a pin only while it uses it
      for (int i = 0; i < PC_W; i++) begin
         if (die_link_pin_use[i]) begin
            st_next.pc_oe[i] = die_link_pin_oe[i];
            st_next.pc_out[i] = pc_alt_out[i];
         end else begin
            st_next.pc_oe[i] = st_next.pc_dir[i];
            st_next.pc_out[i] = st_next.pc_latch[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------

   // all implemented bits clear on reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------

   // pin drive comes from the state flops
   assign pa_pin_out = st_reg.pa_out;
   assign pa_pin_oe = st_reg.pa_oe;
   assign pc_pin_out = st_reg.pc_out;
   assign pc_pin_oe = st_reg.pc_oe;

   // synchronised levels toward the peripherals
   assign spi_pin_level = pa_sync[SPI_W-1:0];
   assign die_link_interrupt_in = pc_sync[PC_INT_BIT];

endmodule : pig_gpio_top
`default_nettype wire

// ---- design/pig_pkg.sv ----
// package for the port a / port c general purpose pin block
// assumes one 10 MHz bus clock and an apb register bus with 32-bit data
package pig_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_W = 10;
   localparam int REG_W = 8;
   localparam int PA_W = 6;
   localparam int PC_W = 2;
   localparam int SPI_W = 4;
   localparam int PIN_W = PA_W + PC_W;

   // ----------------------------------------------------------------
   // register indices; byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_PA_LATCH = 10'h000;
   localparam logic [IDX_W-1:0] IDX_SPARE_ONE = 10'h001;
   localparam logic [IDX_W-1:0] IDX_PA_DIR = 10'h002;
   localparam logic [IDX_W-1:0] IDX_SPARE_THREE = 10'h003;
   localparam logic [IDX_W-1:0] IDX_PC_LATCH = 10'h004;
   localparam logic [IDX_W-1:0] IDX_PC_DIR = 10'h006;
   localparam logic [1:0] WORD_ALIGN = 2'h0;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int PA_SS_BIT = 3;
   localparam int PA_SCK_BIT = 2;
   localparam int PA_MOSI_BIT = 1;
   localparam int PA_MISO_BIT = 0;
   localparam int PC_INT_BIT = 1;
   localparam int PC_CLK_BIT = 0;
   localparam logic [PA_W-1:0] PA_RESET = 6'h00;
   localparam logic [PC_W-1:0] PC_RESET = 2'h0;
   localparam logic [PIN_W-1:0] PIN_RESET = 8'h00;
   localparam logic [REG_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

   // ----------------------------------------------------------------
   // state types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [PIN_W-1:0] meta;
      logic [PIN_W-1:0] stable;
   } pig_sync_state_type;

   typedef struct packed {
      logic ready;
      logic slverr;
      logic [DATA_W-1:0] rdata;
   } pig_apb_state_type;

   typedef struct packed {
      logic [PA_W-1:0] pa_latch;
      logic [PA_W-1:0] pa_dir;
      logic [PC_W-1:0] pc_latch;
      logic [PC_W-1:0] pc_dir;
      logic [PA_W-1:0] pa_out;
      logic [PA_W-1:0] pa_oe;
      logic [PC_W-1:0] pc_out;
      logic [PC_W-1:0] pc_oe;
   } pig_gpio_state_type;

   // ----------------------------------------------------------------
   // decode: is an index backed by a register or spare slot
   // ----------------------------------------------------------------
   function automatic logic pig_mapped(input logic [IDX_W-1:0] idx);
      pig_mapped = (idx == IDX_PA_LATCH) || (idx == IDX_SPARE_ONE) ||
                   (idx == IDX_PA_DIR) || (idx == IDX_SPARE_THREE) ||
                   (idx == IDX_PC_LATCH) || (idx == IDX_PC_DIR);
   endfunction : pig_mapped

endpackage : pig_pkg

// ---- design/pig_sync.sv ----
// two-flop synchroniser for the port a and port c pin levels
// assumes pins are asynchronous to the bus clock
`timescale 1ns/100ps
`default_nettype none
module pig_sync (
   input wire logic clock, // bus clock
   input wire logic rst_n, // async reset, active low
   input wire logic [pig_pkg::PIN_W-1:0] pin_async, // raw pins
   output logic [pig_pkg::PIN_W-1:0] pin_sync // synchronised pins
);
   import pig_pkg::*;

   pig_sync_state_type st_reg;
   pig_sync_state_type st_next;

   // first stage feeds only the second stage
   always_comb begin
      st_next = st_reg;
      for (int i = 0; i < PIN_W; i++) begin
         st_next.meta[i] = pin_async[i];
         st_next.stable[i] = st_reg.meta[i];
      end
   end

   // state registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pin_sync = st_reg.stable;

endmodule : pig_sync
`default_nettype wire

// ---- testbench/pig_gpio_properties.sv ----
// assertions on the port a / port c pin block top ports
// assumes one bus clock and an active low async reset
`timescale 1ns/100ps
`default_nettype none
module pig_gpio_props (
   input wire logic clock, // bus clock
   input wire logic rst_n, // async reset
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic [pig_pkg::ADDR_W-1:0] paddr, // byte address
   input wire logic [pig_pkg::DATA_W-1:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic pslverr, // error
   input wire logic [pig_pkg::PA_W-1:0] pa_pin_in, // port a levels
   input wire logic [pig_pkg::PA_W-1:0] pa_pin_out, // port a drive
   input wire logic [pig_pkg::PA_W-1:0] pa_pin_oe, // port a enable
   input wire logic [pig_pkg::PC_W-1:0] pc_pin_out, // port c drive
   input wire logic [pig_pkg::PC_W-1:0] pc_pin_oe, // port c enable
   input wire logic [pig_pkg::SPI_W-1:0] spi_pin_use, // spi owns
   input wire logic [pig_pkg::SPI_W-1:0] spi_pin_drive, // spi value
   input wire logic [pig_pkg::SPI_W-1:0] spi_pin_oe, // spi enable
   input wire logic [pig_pkg::SPI_W-1:0] spi_pin_level, // synced
   input wire logic [pig_pkg::PC_W-1:0] die_link_pin_use, // link owns
   input wire logic die_link_clock_out, // link clock
   input wire logic [pig_pkg::PC_W-1:0] die_link_pin_oe // link enable
);
   import pig_pkg::*;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // bus phases
   // ----------------------------------------------------------------
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable && pready;
   endsequence
   chk_ready_one: assert property (setup_s |=> access_s)
      else $error("ready missing after setup");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_err_unaligned: assert property (
      (setup_s and paddr[1:0] != 2'h0) |=> pslverr && prdata == ZERO_WORD)
      else $error("unaligned access not refused");
   chk_spare_zero: assert property (
      (setup_s and (paddr == 12'h004 || paddr == 12'h00C)) |=>
      prdata == ZERO_WORD && !pslverr)
      else $error("spare slot not zero");
   chk_upper_zero: assert property (
      (setup_s and paddr[11:4] == 8'h00) |=> prdata[31:6] == 26'h0)
      else $error("upper read bits not zero");
   // ----------------------------------------------------------------
   // pin ownership
   // ----------------------------------------------------------------
   chk_spi_drive: assert property (
      1'b1 |=> ((pa_pin_oe[3:0] ^ $past(spi_pin_oe)) & $past(spi_pin_use))
      == 4'h0 && ((pa_pin_out[3:0] ^ $past(spi_pin_drive)) &
      $past(spi_pin_use & spi_pin_oe)) == 4'h0)
      else $error("spi override wrong");
   chk_link_clock: assert property (
      die_link_pin_use[0] && die_link_pin_oe[0] |=> pc_pin_oe[0] &&
      pc_pin_out[0] == $past(die_link_clock_out))
      else $error("link clock not on pin");
   chk_link_dir: assert property (
      die_link_pin_use[1] |=> pc_pin_oe[1] == $past(die_link_pin_oe[1]))
      else $error("link direction not applied");
   // the release edge itself still shows flops cleared by reset
   chk_spi_sync: assert property (
      (rst_n && $stable(pa_pin_in)) [*3] |-> spi_pin_level == pa_pin_in[3:0])
      else $error("synced level wrong");
endmodule : pig_gpio_props
bind pig_gpio_top pig_gpio_props u_props (.clock, .rst_n, .psel,
   .penable, .paddr, .prdata, .pready, .pslverr, .pa_pin_in, .pa_pin_out,
   .pa_pin_oe, .pc_pin_out, .pc_pin_oe, .spi_pin_use, .spi_pin_drive,
   .spi_pin_oe, .spi_pin_level, .die_link_pin_use, .die_link_clock_out,
   .die_link_pin_oe);
`default_nettype wire

// ---- testbench/pig_gpio_tb.sv ----
// self-checking bench for the port a / port c pin block
// assumes pig_pkg, the pin model and the bound checker are compiled
`timescale 1ns/100ps
`default_nettype none
module port_a_c_gpio_registers_tb_top;
   import pig_pkg::*;
   typedef struct packed {
      logic w;
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] d;
      logic [DATA_W-1:0] x;
      logic e;
   } pig_row_type;
   logic clock, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata;
   logic [PA_W-1:0] pa_pin_in, pa_pin_out, pa_pin_oe, pa_ext;
   logic [PC_W-1:0] pc_pin_in, pc_pin_out, pc_pin_oe, pc_ext;
   logic [SPI_W-1:0] spi_pin_use, spi_pin_drive, spi_pin_oe, spi_pin_level;
   logic [PC_W-1:0] die_link_pin_use, die_link_pin_oe;
   logic die_link_clock_out, die_link_interrupt_in;
   int n_fail = 0;
   int n_tests = 0;
   pig_row_type rows [21] = '{
      '{1'h0,12'h008,32'h0,32'h0,1'h0}, '{1'h0,12'h018,32'h0,32'h0,1'h0},
      '{1'h0,12'h004,32'h0,32'h0,1'h0}, '{1'h0,12'h00C,32'h0,32'h0,1'h0},
      '{1'h1,12'h008,32'hFFFFFFFF,32'h0,1'h0}, '{1'h0,12'h008,32'h0,32'h3F,1'h0},
      '{1'h1,12'h000,32'hFFFFFF15,32'h0,1'h0}, '{1'h0,12'h000,32'h0,32'h15,1'h0},
      '{1'h1,12'h004,32'hFF,32'h0,1'h0}, '{1'h0,12'h004,32'h0,32'h0,1'h0},
      '{1'h1,12'h00C,32'hFF,32'h0,1'h0}, '{1'h0,12'h00C,32'h0,32'h0,1'h0},
      '{1'h1,12'h018,32'hFF,32'h0,1'h0}, '{1'h0,12'h018,32'h0,32'h3,1'h0},
      '{1'h1,12'h010,32'hFF,32'h0,1'h0}, '{1'h0,12'h010,32'h0,32'h3,1'h0},
      '{1'h1,12'h008,32'h0F,32'h0,1'h0}, '{1'h0,12'h014,32'h0,32'h0,1'h1},
      '{1'h1,12'h001,32'h3F,32'h0,1'h1}, '{1'h0,12'h000,32'h0,32'h25,1'h0},
      '{1'h0,12'h000,32'h0,32'h25,1'h0}};
   // design and far side pins
   pig_gpio_top DUT (.clock(clock), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pa_pin_in(pa_pin_in), .pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe),
      .pc_pin_in(pc_pin_in), .pc_pin_out(pc_pin_out), .pc_pin_oe(pc_pin_oe),
      .spi_pin_use(spi_pin_use), .spi_pin_drive(spi_pin_drive),
      .spi_pin_oe(spi_pin_oe), .spi_pin_level(spi_pin_level),
      .die_link_pin_use(die_link_pin_use),
      .die_link_clock_out(die_link_clock_out),
      .die_link_pin_oe(die_link_pin_oe),
      .die_link_interrupt_in(die_link_interrupt_in));
   pig_pin_model u_pins (.pa_out(pa_pin_out), .pa_oe(pa_pin_oe),
      .pc_out(pc_pin_out), .pc_oe(pc_pin_oe), .pa_ext(pa_ext),
      .pc_ext(pc_ext), .pa_pin(pa_pin_in), .pc_pin(pc_pin_in));
   // 100 ns bus clock
   initial begin
      clock = 1'h0;
      forever #50 clock = ~clock;
   end
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   task automatic chk_word(input logic [DATA_W-1:0] g, x);
      n_tests++;
      if (g !== x) begin
         n_fail++;
         $display("BAD %0t word got %h want %h", $time, g, x);
      end
   endtask : chk_word
   task automatic chk_bit(input logic g, x);
      n_tests++;
      if (g !== x) begin
         n_fail++;
         $display("BAD %0t bit got %b want %b", $time, g, x);
      end
   endtask : chk_bit
   // one apb transfer, waits for ready under a bound
   task automatic acc(input pig_row_type r);
      int n;
      logic [DATA_W-1:0] rd;
      logic er;
      n = 0;
      @(posedge clock);
      psel <= 1'h1;
      pwrite <= r.w;
      paddr <= r.a;
      pwdata <= r.d;
      @(posedge clock);
      penable <= 1'h1;
      // ready, read data and error are taken at the same rising edge
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         n_fail++;
         results();
      end
      if (!r.w) chk_word(rd, r.x);
      chk_bit(er, r.e);
   endtask : acc
   task automatic settle();
      repeat (4) @(posedge clock);
   endtask : settle
   task automatic do_reset();
      @(posedge clock);
      rst_n <= 1'h0;
      repeat (2) @(posedge clock);
      chk_word(DATA_W'({pa_pin_oe, pc_pin_oe}), 32'h0);
      rst_n <= 1'h1;
   endtask : do_reset
   // main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {spi_pin_use, spi_pin_drive, spi_pin_oe} = '0;
      {die_link_pin_use, die_link_pin_oe, die_link_clock_out} = '0;
      pa_ext = 6'h2A;
      pc_ext = 2'h1;
      rst_n = 1'h0;
      repeat (2) @(posedge clock);
      rst_n <= 1'h1;
      foreach (rows[i]) acc(rows[i]);
      settle();
      chk_word(DATA_W'(pa_pin_oe), 32'h0F);
      chk_word(DATA_W'(pa_pin_out & pa_pin_oe), 32'h05);
      chk_word(DATA_W'({pc_pin_oe, pc_pin_out}), 32'hF);
      // spi takes pins 3..0
      spi_pin_use <= 4'hF;
      spi_pin_oe <= 4'hA;
      spi_pin_drive <= 4'h6;
      pa_ext <= 6'h15;
      settle();
      chk_word(DATA_W'(pa_pin_oe), 32'h0A);
      chk_word(DATA_W'(pa_pin_out & pa_pin_oe), 32'h02);
      chk_word(DATA_W'(spi_pin_level), 32'h7);
      acc('{1'h0, 12'h008, 32'h0, 32'h0F, 1'h0});
      acc('{1'h0, 12'h000, 32'h0, 32'h15, 1'h0});
      acc('{1'h1, 12'h008, 32'h30, 32'h0, 1'h0});
      settle();
      chk_word(DATA_W'(pa_pin_oe), 32'h3A);
      spi_pin_use <= 4'h0;
      settle();
      chk_word(DATA_W'(pa_pin_oe), 32'h30);
      // die link takes port c
      die_link_pin_use <= 2'h3;
      die_link_pin_oe <= 2'h1;
      die_link_clock_out <= 1'h1;
      pc_ext <= 2'h2;
      settle();
      chk_word(DATA_W'({pc_pin_oe, pc_pin_out[0]}), 32'h3);
      chk_bit(die_link_interrupt_in, 1'h1);
      acc('{1'h0, 12'h018, 32'h0, 32'h3, 1'h0});
      die_link_clock_out <= 1'h0;
      settle();
      chk_bit(pc_pin_out[0], 1'h0);
      die_link_pin_use <= 2'h0;
      settle();
      chk_word(DATA_W'(pc_pin_oe), 32'h3);
      // second reset in mid-run
      do_reset();
      acc('{1'h0, 12'h008, 32'h0, 32'h0, 1'h0});
      acc('{1'h0, 12'h018, 32'h0, 32'h0, 1'h0});
      acc('{1'h0, 12'h010, 32'h0, 32'h2, 1'h0});
      acc('{1'h1, 12'h008, 32'h3F, 32'h0, 1'h0});
      acc('{1'h0, 12'h000, 32'h0, 32'h0, 1'h0});
      results();
   end
endmodule : port_a_c_gpio_registers_tb_top
`default_nettype wire

// ---- testbench/pig_pin_model.sv ----
// far side of the port a / port c pins: resolves each wire level
// assumes the far side always drives a level where the device does not
`timescale 1ns/100ps
`default_nettype none
module pig_pin_model (
   input wire logic [pig_pkg::PA_W-1:0] pa_out, // device drive
   input wire logic [pig_pkg::PA_W-1:0] pa_oe, // device enable
   input wire logic [pig_pkg::PC_W-1:0] pc_out, // device drive
   input wire logic [pig_pkg::PC_W-1:0] pc_oe, // device enable
   input wire logic [pig_pkg::PA_W-1:0] pa_ext, // far side level
   input wire logic [pig_pkg::PC_W-1:0] pc_ext, // far side level
   output logic [pig_pkg::PA_W-1:0] pa_pin, // wire level
   output logic [pig_pkg::PC_W-1:0] pc_pin // wire level
);
   // device drive wins, an input pin shows the far side
   assign pa_pin = (pa_out & pa_oe) | (pa_ext & ~pa_oe);
   assign pc_pin = (pc_out & pc_oe) | (pc_ext & ~pc_oe);
endmodule : pig_pin_model
`default_nettype wire
